// ==== shared/vtg_pkg.sv ====
// vtg_pkg: raster constants, carrier types and shared helpers for the timing generator
package vtg_pkg;

   // ------------------------------------------------------------------
   // raster geometry in pixel clocks and lines
   // ------------------------------------------------------------------
   localparam int H_VIS   = 640;
   localparam int H_FP    = 16;
   localparam int H_PW    = 96;
   localparam int H_BP    = 48;
   localparam int H_TOTAL = H_VIS + H_FP + H_PW + H_BP;
   localparam int V_VIS   = 480;
   localparam int V_FP    = 10;
   localparam int V_PW    = 2;
   localparam int V_BP    = 29;
   localparam int V_TOTAL = V_VIS + V_FP + V_PW + V_BP;

   // nominal pixel clock; one core clock is one pixel
   localparam int PIX_CLK_MHZ = 25;

   // ------------------------------------------------------------------
   // counter decode points
   // ------------------------------------------------------------------
   localparam int CNT_W = 10;
   localparam logic [CNT_W-1:0] CNT_ZERO     = 10'h000;
   localparam logic [CNT_W-1:0] CNT_ONE      = 10'h001;
   localparam logic [CNT_W-1:0] H_MAX        = CNT_W'(H_TOTAL - 1);
   localparam logic [CNT_W-1:0] H_LAST_VIS   = CNT_W'(H_VIS - 1);
   localparam logic [CNT_W-1:0] H_SYNC_BEG   = CNT_W'(H_VIS + H_FP);
   localparam logic [CNT_W-1:0] H_SYNC_END   = CNT_W'(H_VIS + H_FP + H_PW - 1);
   localparam logic [CNT_W-1:0] V_MAX        = CNT_W'(V_TOTAL - 1);
   localparam logic [CNT_W-1:0] V_LAST_VIS   = CNT_W'(V_VIS - 1);
   localparam logic [CNT_W-1:0] V_SYNC_BEG   = CNT_W'(V_VIS + V_FP);
   localparam logic [CNT_W-1:0] V_SYNC_END   = CNT_W'(V_VIS + V_FP + V_PW - 1);
   // fetch runs this many pixels ahead of the displayed position
   localparam logic [CNT_W-1:0] FETCH_LEAD   = 10'h001;

   // ------------------------------------------------------------------
   // video memory
   // ------------------------------------------------------------------
   localparam int ADDR_W    = 19;
   localparam int MEM_DEPTH = H_VIS * V_VIS;

   // ------------------------------------------------------------------
   // carrier types
   // ------------------------------------------------------------------
   typedef struct packed {
      logic red_out;
      logic green_out;
      logic blue_out;
   } vtg_rgb_t;

   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      vtg_rgb_t          rgb;
   } vtg_wr_t;

   typedef struct packed {
      logic [CNT_W-1:0] col;
      logic [CNT_W-1:0] row;
   } vtg_pos_t;

   typedef enum logic [2:0] {
      BUF_EMPTY = 3'b001,
      BUF_ONE   = 3'b010,
      BUF_FULL  = 3'b100
   } vtg_buf_st_t;

   localparam vtg_rgb_t RGB_BLANK = 3'h0;
   localparam vtg_pos_t POS_HOME  = 20'h00000;

   // ------------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------------
   // advance one pixel; row steps once per line, at the line wrap
   function automatic vtg_pos_t vtg_next_pos(input vtg_pos_t p);
      vtg_pos_t n;
      n = p;
      if (p.col == H_MAX) begin
         n.col = CNT_ZERO;
         n.row = (p.row == V_MAX) ? CNT_ZERO : CNT_W'(p.row + CNT_ONE);
      end else begin
         n.col = CNT_W'(p.col + CNT_ONE);
      end
      return n;
   endfunction

   function automatic logic vtg_in_win(input vtg_pos_t p);
      return (p.col <= H_LAST_VIS) && (p.row <= V_LAST_VIS);
   endfunction

   // row-major address, row * 640 + column
   function automatic logic [ADDR_W-1:0] vtg_pix_addr(input vtg_pos_t p);
      return ADDR_W'(p.row) * ADDR_W'(H_VIS) + ADDR_W'(p.col);
   endfunction

endpackage

// ==== hdl/vtg_pix_mem.sv ====
// vtg_pix_mem: single-port video refresh memory with registered read data
`timescale 1ns/10ps
module vtg_pix_mem (
   // clock and enable
   input  wire logic                      core_clk_i,
   input  wire logic                      ce_i,
   // single access port
   input  wire logic                      we_i,
   input  wire logic                      re_i,
   input  wire logic [vtg_pkg::ADDR_W-1:0] addr_i,
   input  wire vtg_pkg::vtg_rgb_t          wdata_i,
   output vtg_pkg::vtg_rgb_t               rdata_o
);
   import vtg_pkg::*;

   vtg_rgb_t mem_q [0:MEM_DEPTH-1];
   vtg_rgb_t rd_q;

   // one port: write and read never share a cycle, caller arbitrates
   always_ff @(posedge core_clk_i) begin
      if (ce_i) begin
         if (we_i) begin
            mem_q[addr_i] <= wdata_i;
         end
         if (re_i) begin
            rd_q <= mem_q[addr_i];
         end
      end
   end

   assign rdata_o = rd_q;
endmodule

// ==== hdl/vtg_wr_buf.sv ====
// vtg_wr_buf: two-entry valid/ready buffer on the pixel write path
`timescale 1ns/10ps
module vtg_wr_buf (
   // clock, reset, enable
   input  wire logic       core_clk_i,
   input  wire logic       rst_n_i,
   input  wire logic       ce_i,
   // filling side
   input  wire logic       in_valid_i,
   input  vtg_pkg::vtg_wr_t in_data_i,
   output logic            in_ready_o,
   // draining side
   output logic            out_valid_o,
   output vtg_pkg::vtg_wr_t out_data_o,
   input  wire logic       out_ready_i
);
   import vtg_pkg::*;

   vtg_buf_st_t st_q, st_d;
   vtg_wr_t     head_q, head_d;
   vtg_wr_t     tail_q, tail_d;
   logic        rdy_q;
   logic        push_w;
   logic        pop_w;

   assign push_w = in_valid_i && rdy_q;
   assign pop_w  = (st_q != BUF_EMPTY) && out_ready_i;

   // occupancy and entry movement
   always_comb begin
      st_d   = st_q;
      head_d = head_q;
      tail_d = tail_q;
      case (st_q)
         BUF_EMPTY: begin
            if (push_w) begin
               head_d = in_data_i;
               st_d   = BUF_ONE;
            end
         end
         BUF_ONE: begin
            if (push_w && pop_w) begin
               head_d = in_data_i;
            end else if (push_w) begin
               tail_d = in_data_i;
               st_d   = BUF_FULL;
            end else if (pop_w) begin
               st_d   = BUF_EMPTY;
            end
         end
         BUF_FULL: begin
            if (pop_w) begin
               head_d = tail_q;
               st_d   = BUF_ONE;
            end
         end
         default: st_d = BUF_EMPTY;
      endcase
   end

   // ready is registered so the top can drive it straight from a flop
   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         st_q  <= BUF_EMPTY;
         rdy_q <= 1'b1;
      end else if (ce_i) begin
         st_q  <= st_d;
         rdy_q <= (st_d != BUF_FULL);
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (ce_i) begin
         head_q <= head_d;
         tail_q <= tail_d;
      end
   end

   assign in_ready_o  = rdy_q;
   assign out_valid_o = (st_q != BUF_EMPTY);
   assign out_data_o  = head_q;
endmodule

// ==== hdl/vtg_timing_gen.sv ====
// vtg_timing_gen: 640x480 raster timing generator with frame store and pixel fetch
//
// Functional notes
// - core clock must be the 25 MHz pixel clock, one pixel per clock, ~60 Hz.
// - free-running column counter wraps after 800; horizontal sync decoded from it.
// - line is 640 visible, 16 front porch, 96 sync, 48 back porch.
// - row counter steps once per line, wraps after 521; vertical sync decoded.
// - frame is 480 visible, 10 front porch, 2 sync, 29 back porch lines.
// - colour outputs are blanked during all porches and sync intervals.
// - column and row counters give position and form the video memory address.
// - three colour bits per pixel, one each for red, green, blue.
// - pixel data fetched ahead so colour lines up with its pixel period.
// - no fixed phase between horizontal and vertical sync starts is needed.
`timescale 1ns/10ps
module vtg_timing_gen (
   // clock, reset, enable
   input  wire logic                        core_clk_i,
   input  wire logic                        rst_n_i,
   input  wire logic                        ce_i,
   // pixel write stream into the frame store
   input  wire logic                        wr_valid_i,
   input  vtg_pkg::vtg_wr_t                 wr_i,
   output logic                             wr_ready_o,
   // monitor side
   output vtg_pkg::vtg_rgb_t                rgb_o,
   output logic                             hsync_n_o,
   output logic                             vsync_n_o,
   // raster position of the pixel now on the outputs
   output logic [vtg_pkg::CNT_W-1:0]        pix_col_o,
   output logic [vtg_pkg::CNT_W-1:0]        pix_row_o
);
   import vtg_pkg::*;

   // ------------------------------------------------------------------
   // declarations
   // ------------------------------------------------------------------
   vtg_pos_t          disp_q;
   vtg_pos_t          fetch_q;
   logic              rd_vld_q;
   vtg_rgb_t          rgb_q;
   logic              hs_n_q;
   logic              vs_n_q;
   vtg_pos_t          pos_out_q;

   vtg_pos_t          disp_nxt_w;
   vtg_pos_t          fetch_nxt_w;
   logic              disp_vis_w;
   logic              fetch_rd_w;
   logic              hs_act_w;
   logic              vs_act_w;
   vtg_rgb_t          rgb_d;
   logic [ADDR_W-1:0] mem_addr_w;
   vtg_rgb_t          mem_rd_w;
   logic              buf_vld_w;
   vtg_wr_t           buf_data_w;
   logic              buf_ready_w;
   logic              mem_we_w;

   // ------------------------------------------------------------------
   // raster counters
   // ------------------------------------------------------------------
   // column wraps at 799
   assign disp_nxt_w  = vtg_next_pos(disp_q);
   assign fetch_nxt_w = vtg_next_pos(fetch_q);

   // fetch pair runs one pixel ahead; both freeze with the enable
   // reset to first pixel
   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         disp_q  <= POS_HOME;
         fetch_q <= '{col: FETCH_LEAD, row: CNT_ZERO};
      end else if (ce_i) begin
         disp_q  <= disp_nxt_w;
         fetch_q <= fetch_nxt_w;
      end
   end

   // ------------------------------------------------------------------
   // window and sync decode
   // ------------------------------------------------------------------
   // horizontal sync window
   assign hs_act_w   = (disp_q.col >= H_SYNC_BEG) && (disp_q.col <= H_SYNC_END);
   assign vs_act_w   = (disp_q.row >= V_SYNC_BEG) && (disp_q.row <= V_SYNC_END);
   assign disp_vis_w = vtg_in_win(disp_q);
   assign fetch_rd_w = vtg_in_win(fetch_q);

   // ------------------------------------------------------------------
   // frame store access
   // ------------------------------------------------------------------
   // address from row and column
   assign mem_addr_w = fetch_rd_w ? vtg_pix_addr(fetch_q) : buf_data_w.addr;
   // reads own the port in the visible window, writes drain in blanking
   assign buf_ready_w = !fetch_rd_w;
   assign mem_we_w    = buf_vld_w && buf_ready_w;

   vtg_wr_buf u_wr_buf (
      .core_clk_i  (core_clk_i),
      .rst_n_i     (rst_n_i),
      .ce_i        (ce_i),
      .in_valid_i  (wr_valid_i),
      .in_data_i   (wr_i),
      .in_ready_o  (wr_ready_o),
      .out_valid_o (buf_vld_w),
      .out_data_o  (buf_data_w),
      .out_ready_i (buf_ready_w)
   );

   vtg_pix_mem u_pix_mem (
      .core_clk_i (core_clk_i),
      .ce_i       (ce_i),
      .we_i       (mem_we_w),
      .re_i       (fetch_rd_w),
      .addr_i     (mem_addr_w),
      .wdata_i    (buf_data_w.rgb),
      .rdata_o    (mem_rd_w)
   );

   // track read data one clock behind the fetch
   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         rd_vld_q <= 1'b0;
      end else if (ce_i) begin
         rd_vld_q <= fetch_rd_w;
      end
   end

   // ------------------------------------------------------------------
   // output stage
   // ------------------------------------------------------------------
   // blank outside the window
   assign rgb_d = (disp_vis_w && rd_vld_q) ? mem_rd_w : RGB_BLANK;

   // every monitor-side output is a flop, so all share one delay
   // syncs low while active
   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         rgb_q     <= RGB_BLANK;
         hs_n_q    <= 1'b1;
         vs_n_q    <= 1'b1;
         pos_out_q <= POS_HOME;
      end else if (ce_i) begin
         rgb_q     <= rgb_d;
         hs_n_q    <= !hs_act_w;
         vs_n_q    <= !vs_act_w;
         pos_out_q <= disp_q;
      end
   end

   assign rgb_o     = rgb_q;
   assign hsync_n_o = hs_n_q;
   assign vsync_n_o = vs_n_q;
   assign pix_col_o = pos_out_q.col;
   assign pix_row_o = pos_out_q.row;

   // ------------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------------
   default clocking cb_core @(posedge core_clk_i);
   endclocking
   default disable iff (!rst_n_i);

   sequence s_frame_end;
      ce_i && (disp_q.col == H_MAX) && (disp_q.row == V_MAX);
   endsequence

   sequence s_hs_enter;
      ce_i && (disp_q.col == H_SYNC_BEG);
   endsequence

   sequence s_hs_leave;
      ce_i && (disp_q.col == H_SYNC_END);
   endsequence

   // frame closes on the 800 x 521 boundary
   property p_frame_wrap;
      s_frame_end |=> (disp_q.col == CNT_ZERO) && (disp_q.row == CNT_ZERO);
   endproperty
   a_frame_wrap: assert property (p_frame_wrap)
      else $error("frame did not wrap to origin");

   property p_col_wrap;
      ce_i && (disp_q.col == H_MAX) |=> (disp_q.col == CNT_ZERO);
   endproperty
   a_col_wrap: assert property (p_col_wrap)
      else $error("column did not wrap after 800");

   // the edge after column 656 is the first low one, the one before it high
   property p_hs_pulse;
      s_hs_enter |=> !hsync_n_o && $past(hsync_n_o);
   endproperty
   a_hs_pulse: assert property (p_hs_pulse)
      else $error("hsync did not start at column 656");

   property p_hs_end;
      s_hs_leave ##1 ce_i |=> hsync_n_o;
   endproperty
   a_hs_end: assert property (p_hs_end)
      else $error("hsync did not end after 96 clocks");

   property p_row_step;
      ce_i && (disp_q.col == H_MAX) && (disp_q.row != V_MAX)
         |=> (disp_q.row == $past(disp_q.row) + CNT_ONE);
   endproperty
   a_row_step: assert property (p_row_step)
      else $error("row did not step at line end");

   property p_vs_level;
      ce_i |=> (vsync_n_o == !$past(vs_act_w)) && ($past(vs_act_w) ==
         (($past(disp_q.row) == V_SYNC_BEG) || ($past(disp_q.row) == V_SYNC_END)));
   endproperty
   a_vs_level: assert property (p_vs_level)
      else $error("vsync not low exactly on lines 490 and 491");

   property p_blank;
      ce_i && !disp_vis_w |=> (rgb_o == RGB_BLANK);
   endproperty
   a_blank: assert property (p_blank)
      else $error("colour driven outside visible window");

   property p_addr;
      fetch_rd_w |-> (mem_addr_w == ADDR_W'(fetch_q.row) * ADDR_W'(H_VIS)
         + ADDR_W'(fetch_q.col));
   endproperty
   a_addr: assert property (p_addr)
      else $error("fetch address not row*640+col");

   property p_pos_out;
      ce_i |=> (pix_col_o == $past(disp_q.col)) && (pix_row_o == $past(disp_q.row));
   endproperty
   a_pos_out: assert property (p_pos_out)
      else $error("reported position out of step with colour");

   // the home pixel right after reset was never fetched, so it is left out
   property p_fetch_lead;
      ce_i && disp_vis_w && (rd_vld_q || (disp_q != POS_HOME))
         |=> (rgb_o == $past(mem_rd_w)) && $past(rd_vld_q);
   endproperty
   a_fetch_lead: assert property (p_fetch_lead)
      else $error("visible pixel not taken from prefetched data");

   property p_reset_home;
      $rose(rst_n_i) |-> (disp_q == POS_HOME) && (rgb_o == RGB_BLANK)
         && hsync_n_o && vsync_n_o;
   endproperty
   a_reset_home: assert property (p_reset_home)
      else $error("reset did not home the raster");

   // a drained word must really land, and only while the fetch is idle
   property p_no_clash;
      ce_i && mem_we_w |=> !$past(fetch_rd_w)
         && (u_pix_mem.mem_q[$past(mem_addr_w)] == $past(buf_data_w.rgb));
   endproperty
   a_no_clash: assert property (p_no_clash)
      else $error("buffered write lost or collided with pixel fetch");

   // column steps by one inside a line
   property p_col_step;
      ce_i && (disp_q.col != H_MAX) |=> (disp_q.col == $past(disp_q.col) + CNT_ONE);
   endproperty
   a_col_step: assert property (p_col_step)
      else $error("column did not step by one");

   // row only moves at the column wrap, so both syncs share one origin
   property p_row_hold;
      ce_i && (disp_q.col != H_MAX) |=> (disp_q.row == $past(disp_q.row));
   endproperty
   a_row_hold: assert property (p_row_hold)
      else $error("row moved inside a line");

   // fetch pair stays exactly one pixel ahead, wraps included
   property p_fetch_ahead;
      fetch_q == vtg_next_pos(disp_q);
   endproperty
   a_fetch_ahead: assert property (p_fetch_ahead)
      else $error("fetch position not one pixel ahead");

   // a low enable freezes raster, outputs and buffer
   property p_freeze;
      !ce_i |=> $stable(disp_q) && $stable(rgb_o) && $stable(hsync_n_o)
         && $stable(vsync_n_o) && $stable(wr_ready_o);
   endproperty
   a_freeze: assert property (p_freeze)
      else $error("state moved while enable low");

   // a write into the empty buffer is offered to the store next clock
   property p_buf_take;
      ce_i && wr_valid_i && wr_ready_o && !buf_vld_w
         |=> buf_vld_w && (buf_data_w == $past(wr_i));
   endproperty
   a_buf_take: assert property (p_buf_take)
      else $error("accepted write not held in buffer");

   // second word while the fetch owns the port fills the buffer
   property p_ready_drop;
      ce_i && wr_valid_i && wr_ready_o && buf_vld_w && !buf_ready_w |=> !wr_ready_o;
   endproperty
   a_ready_drop: assert property (p_ready_drop)
      else $error("ready stayed high with a full buffer");

   // pulse ends on the clock after column 751 is shown
   property p_hs_rise;
      s_hs_leave ##1 ce_i |=> hsync_n_o && !$past(hsync_n_o);
   endproperty
   a_hs_rise: assert property (p_hs_rise)
      else $error("hsync did not rise after column 751");

   // buffer and fetch tracking restart empty after reset
   property p_reset_ready;
      $rose(rst_n_i) |-> wr_ready_o && !buf_vld_w && !rd_vld_q;
   endproperty
   a_reset_ready: assert property (p_reset_ready)
      else $error("buffer not empty after reset");
endmodule

// ==== verif/vtg_monitor_model.sv ====
// vtg_monitor_model: behavioural monitor that measures horizontal sync timing and blanking
`timescale 1ns/10ps
module vtg_monitor_model (
   // pixel clock and enable
   input  wire logic              core_clk_i,
   input  wire logic              ce_i,
   // monitor pins
   input  wire vtg_pkg::vtg_rgb_t rgb_i,
   input  wire logic              hsync_n_i,
   input  wire logic              vsync_n_i,
   // measured timing
   output int                     line_len_o,
   output int                     hs_width_o,
   output int                     blank_err_o
);
   import vtg_pkg::*;

   int   since_fall;
   int   low_len;
   logic hs_q;

   // monitor powers up idle, nothing measured yet
   initial begin
      since_fall  = 0;
      low_len     = 0;
      hs_q        = 1'b1;
      line_len_o  = 0;
      hs_width_o  = 0;
      blank_err_o = 0;
   end

   // a disabled pixel clock is no pixel, so the monitor freezes as well
   always @(posedge core_clk_i) begin
      if (ce_i) begin
         hs_q <= hsync_n_i;
         if (hs_q && !hsync_n_i) begin
            line_len_o <= since_fall;
            since_fall <= 1;
         end else begin
            since_fall <= since_fall + 1;
         end
         if (!hsync_n_i) begin
            low_len <= low_len + 1;
         end else if (!hs_q) begin
            hs_width_o <= low_len;
            low_len    <= 0;
         end
         if (line_len_o > 0 && rgb_i !== 3'h0 && (!vsync_n_i || !hsync_n_i ||
             since_fall < H_PW + H_BP || since_fall >= H_PW + H_BP + H_VIS)) begin
            blank_err_o <= blank_err_o + 1;
         end
      end
   end
endmodule

// ==== verif/vtg_timing_gen_tb.sv ====
// vtg_timing_gen_tb: self-checking bench for the raster timing generator
`timescale 1ns/10ps
module vtg_timing_gen_tb;
   import vtg_pkg::*;

   // ------------------------------------------------------------------
   // signals
   // ------------------------------------------------------------------
   localparam int    CYCLE_LIMIT = 8000;
   logic             core_clk_i;
   logic             rst_n_i;
   logic             ce_i;
   logic             wr_valid_i;
   vtg_wr_t          wr_i;
   logic             wr_ready_o;
   vtg_rgb_t         rgb_o;
   logic             hsync_n_o;
   logic             vsync_n_o;
   logic [CNT_W-1:0] pix_col_o;
   logic [CNT_W-1:0] pix_row_o;
   int               line_len;
   int               hs_width;
   int               blank_err;
   int               mismatches = 0;
   int               n_compared = 0;
   int               cycles = 0;
   int               ec = 0;
   int               er = 0;
   bit               jr = 1'b1;
   vtg_rgb_t         emem [int];

   vtg_timing_gen vtg_timing_gen_i (
      .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .ce_i(ce_i),
      .wr_valid_i(wr_valid_i), .wr_i(wr_i), .wr_ready_o(wr_ready_o),
      .rgb_o(rgb_o), .hsync_n_o(hsync_n_o), .vsync_n_o(vsync_n_o),
      .pix_col_o(pix_col_o), .pix_row_o(pix_row_o)
   );

   vtg_monitor_model vtg_monitor_model_i (
      .core_clk_i(core_clk_i), .ce_i(ce_i), .rgb_i(rgb_o),
      .hsync_n_i(hsync_n_o), .vsync_n_i(vsync_n_o),
      .line_len_o(line_len), .hs_width_o(hs_width), .blank_err_o(blank_err)
   );

   // ------------------------------------------------------------------
   // clock and reference raster
   // ------------------------------------------------------------------
   // 20 MHz bench clock, period 50 ns
   initial begin
      core_clk_i = 1'b0;
      forever #25 core_clk_i = ~core_clk_i;
   end

   // reference walk; the release edge still shows the home pixel
   // one shared origin
   always @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         ec <= 0;
         er <= 0;
         jr <= 1'b1;
      end else if (ce_i) begin
         jr <= 1'b0;
         if (!jr) begin
            ec <= (ec == H_TOTAL - 1) ? 0 : ec + 1;
            if (ec == H_TOTAL - 1) begin
               er <= (er == V_TOTAL - 1) ? 0 : er + 1;
            end
         end
      end
   end

   // every pixel is judged mid-cycle, once the outputs have settled
   always @(negedge core_clk_i) begin
      if (rst_n_i === 1'b1) begin
         cmp_val(pix_col_o, ec, "column");
         cmp_val(pix_row_o, er, "row");
         cmp_val(hsync_n_o, !(ec >= H_VIS + 16 && ec < H_VIS + 112), "hsync");
         cmp_val(vsync_n_o, !(er >= V_VIS + 10 && er < V_VIS + 12), "vsync");
         if (!(ec < 640 && er < 480)) begin
            cmp_val(rgb_o, 0, "blanked colour");
         end else if (emem.exists(er * H_VIS + ec)) begin
            cmp_val(rgb_o, emem[er * H_VIS + ec], "pixel colour");
         end
      end
   end

   // ------------------------------------------------------------------
   // shared tasks
   // ------------------------------------------------------------------
   task automatic cmp_val(input logic [31:0] got, input logic [31:0] exp, input string what);
      n_compared++;
      if (got !== exp) begin
         mismatches++;
         $display("[FAIL] %0t %s got %0h expected %0h", $time, what, got, exp);
      end
   endtask

   task automatic step(input int n);
      repeat (n) @(posedge core_clk_i);
      #1;
   endtask

   // request stays up until an edge sees ready high; caller drops valid
   task automatic wr(input int a, input vtg_rgb_t c);
      int k;
      k = 0;
      wr_valid_i = 1'b1;
      wr_i       = '{addr: a[ADDR_W-1:0], rgb: c};
      while (wr_ready_o !== 1'b1 && k < 2000) begin
         step(1);
         k++;
      end
      if (k >= 2000) begin
         mismatches++;
         $display("[FAIL] %0t write never taken", $time);
      end
      step(1);
      emem[a] = c;
   endtask

   task automatic report_and_stop;
      $display("compared %0d mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   // ------------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------------
   // memory is not cleared by reset, so remembered colours are dropped
   task automatic t_reset;
      rst_n_i = 1'b0;
      emem.delete();
      step(2);
      cmp_val(rgb_o, 0, "reset colour");
      cmp_val({hsync_n_o, vsync_n_o}, 2'b11, "reset syncs");
      cmp_val({pix_col_o, pix_row_o}, 0, "reset position");
      cmp_val(wr_ready_o, 1, "reset ready");
      rst_n_i = 1'b1;
      $display("test reset done");
   endtask

   // writes during the visible span fill the buffer and wait for blanking
   task automatic t_buffer;
      wr(2 * H_VIS + 5, 3'h5);
      wr(2 * H_VIS + 6, 3'h2);
      cmp_val(wr_ready_o, 0, "full buffer");
      wr(2 * H_VIS + 7, 3'h6);
      cmp_val(ec >= H_VIS - 1, 1, "drain in blanking");
      for (int i = 0; i < 8; i++) begin
         wr(3 * H_VIS + i, vtg_rgb_t'(i[2:0]));
      end
      wr(3 * H_VIS + 638, 3'h3);
      wr(3 * H_VIS + 639, 3'h4);
      wr_valid_i = 1'b0;
      $display("test buffer done");
   endtask

   // a paused enable freezes the raster; the reference pauses too
   task automatic t_enable;
      ce_i = 1'b0;
      step(6);
      ce_i = 1'b1;
      $display("test enable done");
   endtask

   // colours of rows 2 and 3 and the line measurements of the monitor
   task automatic t_lines;
      step(3300);
      cmp_val(line_len, H_TOTAL, "line length");
      cmp_val(hs_width, 96, "hsync width");
      cmp_val(blank_err, 0, "colour while blanked");
      $display("test lines done");
   endtask

   // ------------------------------------------------------------------
   // main sequence and hang guard
   // ------------------------------------------------------------------
   initial begin
      rst_n_i    = 1'b0;
      ce_i       = 1'b1;
      wr_valid_i = 1'b0;
      wr_i       = '0;
      t_reset();
      t_buffer();
      t_enable();
      t_lines();
      t_reset();
      step(1000);
      report_and_stop();
   end

   initial begin
      while (cycles < CYCLE_LIMIT) begin
         @(posedge core_clk_i);
         cycles++;
      end
      mismatches++;
      $display("[FAIL] %0t cycle limit reached", $time);
      report_and_stop();
   end
endmodule
